// ---- lgc_pkg.sv ----
// Purpose: shared constants and types for the basic logic gate block
// Assumes: 40 MHz hclk, word-only AHB-Lite access
// Notes: offsets are byte addresses

package lgc_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NGATE = 8;
  localparam int NIN = 4;
  localparam int CNT_W = 16;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INV = 8'h04;
  localparam logic [7:0] OFS_CON = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_SFB = 8'h10;
  localparam logic [7:0] OFS_SFB_CNT = 8'h14;
  localparam logic [7:0] OFS_HOURS = 8'h18;
  localparam logic [7:0] OFS_PINS = 8'h1C;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam int CTRL_RETAIN_BIT = 2;
  localparam int SFB_CON_BIT = 0;
  localparam int SFB_INV_BIT = 1;
  localparam int SFB_Q_BIT = 2;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic RUN_RST = 1'b1;
  localparam logic RETAIN_RST = 1'b0;
  localparam logic [31:0] INV_RST = 32'h0000_0000;
  localparam logic [31:0] CON_RST = 32'hFFFF_FFFF;
  localparam logic SFB_CON_RST = 1'b1;
  localparam logic SFB_INV_RST = 1'b0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_KHZ = 40000;
  localparam int CYCLE_NS = 1000;
  localparam int CYC_CNT = (CYCLE_NS * CLK_KHZ) / 1000000;
  localparam int SFB_DELAY_CYC = 3;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum {LGC_AND, LGC_AND_EDGE, LGC_NAND, LGC_NAND_EDGE,
                LGC_OR, LGC_NOR, LGC_XOR, LGC_NOT} lgc_kind_t;
  typedef enum {BUS_IDLE, BUS_WR, BUS_RD} lgc_bus_t;

endpackage

// ---- lgc_gate_if.sv ----
// Purpose: carrier between the controller and one gate block
// Assumes: all signals on hclk
// Notes: tick marks one evaluation cycle

`timescale 1ns/10ps

interface lgc_gate_if;
  logic tick;
  logic clr;
  logic [3:0] din;
  logic [3:0] inv;
  logic [3:0] con;
  logic q;
  modport ctl (output tick, output clr, output din, output inv, output con, input q);
  modport gate (input tick, input clr, input din, input inv, input con, output q);
endinterface

// ---- lgc_sync.sv ----
// Purpose: two-flop synchroniser for terminal pins
// Assumes: pins are asynchronous levels
// Notes: first stage feeds only the second

`timescale 1ns/10ps

module lgc_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  generate
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end
        else
        begin
          meta_ff <= d[i];
          sync_ff <= meta_ff;
        end
      end
      assign q[i] = sync_ff;
    end
  endgenerate

endmodule // lgc_sync

// ---- lgc_gate.sv ----
// Purpose: one basic Boolean block evaluated once per scan cycle
// Assumes: tick is a one-cycle pulse per evaluation cycle
// Notes: output holds between ticks unless clr clears it

`timescale 1ns/10ps

module lgc_gate #(
  parameter lgc_pkg::lgc_kind_t KIND = lgc_pkg::LGC_AND
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // controller side
  lgc_gate_if.gate g
);
  import lgc_pkg::*;

  // ----------------------------------------
  // input conditioning
  // ----------------------------------------
  localparam logic [3:0] USED = (KIND == LGC_XOR) ? 4'h3 : (KIND == LGC_NOT) ? 4'h1 : 4'hF;
  localparam logic DFLT_HI = (KIND == LGC_AND) || (KIND == LGC_AND_EDGE) ||
                             (KIND == LGC_NAND) || (KIND == LGC_NAND_EDGE);

  logic [3:0] cond;
  logic [3:0] prev_ff;
  logic valid_ff;
  logic q_ff;
  logic nxt_q;

  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_in
      // unused or unconnected inputs take the block's fixed level
      assign cond[i] = (g.con[i] && USED[i]) ? (g.din[i] ^ g.inv[i]) : DFLT_HI;
    end
  endgenerate

  // ----------------------------------------
  // evaluation
  // ----------------------------------------
  always_comb
  begin
    case (KIND)
      LGC_AND: nxt_q = &cond;
      LGC_AND_EDGE: nxt_q = (&cond) && valid_ff && !(&prev_ff);
      LGC_NAND: nxt_q = !(&cond);
      LGC_NAND_EDGE: nxt_q = !(&cond) && valid_ff && (&prev_ff);
      LGC_OR: nxt_q = |cond;
      LGC_NOR: nxt_q = !(|cond);
      LGC_XOR: nxt_q = cond[0] ^ cond[1];
      LGC_NOT: nxt_q = !cond[0];
      default: nxt_q = 1'b0;
    endcase
  end

  // valid_ff stops a false edge on the first cycle after power-up
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_ff <= 4'h0;
      valid_ff <= 1'b0;
    end
    else if (g.clr)
    begin
      valid_ff <= 1'b0;
    end
    else if (g.tick)
    begin
      prev_ff <= cond;
      valid_ff <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q_ff <= 1'b0;
    else if (g.clr)
      q_ff <= 1'b0;
    else if (g.tick)
      q_ff <= nxt_q;
  end

  assign g.q = q_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_PREV: assert property (@(posedge hclk) disable iff (!hresetn)
    (g.tick && !g.clr) |=> (prev_ff == $past(cond)))
    else $error("previous levels not stored");

  generate
    if (KIND == LGC_AND)
    begin : g_a1
      AST_AND: assert property (@(posedge hclk) disable iff (!hresetn)
        (g.tick && !g.clr) |=> (q_ff == (&$past(g.din ^ g.inv | ~g.con))))
        else $error("and output wrong");
    end
    if (KIND == LGC_AND_EDGE)
    begin : g_a2
      AST_AND_EDGE: assert property (@(posedge hclk) disable iff (!hresetn)
        (g.tick && !g.clr) |=> (q_ff == ((&$past(g.din ^ g.inv | ~g.con)) && $past(valid_ff) &&
                                         !(&$past(prev_ff)))))
        else $error("and edge output wrong");
      AST_AND_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
        (g.tick && q_ff) |=> !q_ff)
        else $error("and edge pulse too long");
    end
    if (KIND == LGC_NAND)
    begin : g_a4
      AST_NAND: assert property (@(posedge hclk) disable iff (!hresetn)
        (g.tick && !g.clr) |=> (q_ff != (&$past(g.din ^ g.inv | ~g.con))))
        else $error("nand output wrong");
    end
    if (KIND == LGC_NAND_EDGE)
    begin : g_a5
      AST_NAND_EDGE: assert property (@(posedge hclk) disable iff (!hresetn)
        (g.tick && !g.clr && valid_ff && (&prev_ff) && !(&cond)) |=> q_ff)
        else $error("nand edge missed");
      AST_NAND_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
        (g.tick && q_ff) |=> !q_ff)
        else $error("nand edge pulse too long");
    end
    if (KIND == LGC_OR)
    begin : g_a6
      AST_OR: assert property (@(posedge hclk) disable iff (!hresetn)
        (g.tick && !g.clr) |=> (q_ff == (|$past((g.din ^ g.inv) & g.con))))
        else $error("or output wrong");
    end
    if (KIND == LGC_NOR)
    begin : g_a7
      AST_NOR: assert property (@(posedge hclk) disable iff (!hresetn)
        (g.tick && !g.clr) |=> (q_ff == !(|$past((g.din ^ g.inv) & g.con))))
        else $error("nor output wrong");
    end
    if (KIND == LGC_XOR)
    begin : g_a8
      AST_XOR: assert property (@(posedge hclk) disable iff (!hresetn)
        (g.tick && !g.clr) |=> (q_ff == ^$past((g.din[1:0] ^ g.inv[1:0]) & g.con[1:0])))
        else $error("xor output wrong");
    end
    if (KIND == LGC_NOT)
    begin : g_a9
      AST_NOT: assert property (@(posedge hclk) disable iff (!hresetn)
        (g.tick && !g.clr && g.con[0]) |=> (q_ff == !$past(g.din[0] ^ g.inv[0])))
        else $error("not output wrong");
    end
  endgenerate

endmodule // lgc_gate

// ---- lgc_top.sv ----
// Purpose: bank of scan-cycle basic logic blocks with one special-function block
// Assumes: AHB-Lite word access, 40 MHz hclk, hresetn is power-up
// Notes: a restart request stands in for a power loss of the program

`timescale 1ns/10ps

module lgc_top #(
  parameter int CYC_DIV = lgc_pkg::CYC_CNT,
  parameter int SFB_DELAY = lgc_pkg::SFB_DELAY_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // terminals
  input wire logic [lgc_pkg::NIN-1:0] din_pin,
  input wire logic sfb_trg_pin,
  output logic [lgc_pkg::NGATE-1:0] dout,
  output logic sfb_q
);
  import lgc_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  localparam int DIV_W = (CYC_DIV > 1) ? $clog2(CYC_DIV) : 1;

  generate
    if (CYC_DIV < 1 || SFB_DELAY < 1 || SFB_DELAY >= (1 << CNT_W))
    begin : g_bad
      $error("lgc_top: unsupported parameter value");
    end
  endgenerate

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [NIN:0] pin_sync;
  logic [NIN-1:0] din_s;
  logic trg_s;
  logic run_ff;
  logic retain_ff;
  logic restart_ff;
  logic [31:0] inv_ff;
  logic [31:0] con_ff;
  logic sfb_con_ff;
  logic sfb_inv_ff;
  logic [DIV_W-1:0] div_ff;
  logic tick_ff;
  logic [NGATE-1:0] gate_q;
  logic [NGATE-1:0] dout_ff;
  logic sfb_trg;
  logic [CNT_W-1:0] sfb_cnt_ff;
  logic sfb_q_ff;
  logic [31:0] hours_ff;
  lgc_bus_t bus_ff;
  logic [5:0] waddr_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic ap_ok;
  logic [31:0] rd_mux;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  lgc_sync #(
    .WIDTH(NIN + 1)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({sfb_trg_pin, din_pin}),
    .q(pin_sync)
  );

  assign din_s = pin_sync[NIN-1:0];
  assign trg_s = pin_sync[NIN];

  // ----------------------------------------
  // evaluation cycle timer
  // ----------------------------------------
  // one evaluation per CYC_DIV clocks; halted while run is off
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end
    else if (!run_ff || restart_ff)
    begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end
    else if (div_ff == DIV_W'(CYC_DIV - 1))
    begin
      div_ff <= '0;
      tick_ff <= 1'b1;
    end
    else
    begin
      div_ff <= div_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // gate blocks
  // ----------------------------------------
  generate
    for (genvar i = 0; i < NGATE; i++)
    begin : g_gate
      lgc_gate_if gi ();
      assign gi.tick = tick_ff;
      assign gi.clr = restart_ff;
      assign gi.din = din_s;
      assign gi.inv = inv_ff[4*i +: 4];
      assign gi.con = con_ff[4*i +: 4];
      assign gate_q[i] = gi.q;
      lgc_gate #(
        .KIND(lgc_kind_t'(i))
      ) u_gate (
        .hclk(hclk),
        .hresetn(hresetn),
        .g(gi)
      );
    end
  endgenerate

  // output terminals pass straight out, no inversion offered
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dout_ff <= '0;
    else
      dout_ff <= gate_q;
  end

  // ----------------------------------------
  // special-function block (on-delay)
  // ----------------------------------------
  assign sfb_trg = sfb_con_ff ? (trg_s ^ sfb_inv_ff) : 1'b0;

  // restart models a power loss; retained state is left untouched
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sfb_cnt_ff <= '0;
      sfb_q_ff <= 1'b0;
    end
    else if (restart_ff)
    begin
      if (!retain_ff)
      begin
        sfb_cnt_ff <= '0;
        sfb_q_ff <= 1'b0;
      end
    end
    else if (tick_ff)
    begin
      if (!sfb_trg)
      begin
        sfb_cnt_ff <= '0;
        sfb_q_ff <= 1'b0;
      end
      else if (sfb_cnt_ff < CNT_W'(SFB_DELAY))
        sfb_cnt_ff <= sfb_cnt_ff + 1'b1;
      else
        sfb_q_ff <= 1'b1;
    end
  end

  // hours counter is not cleared by restart; a tick in the restart cycle is not counted
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hours_ff <= '0;
    else if (tick_ff && !restart_ff)
      hours_ff <= hours_ff + 1'b1;
  end

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  assign ap_ok = hsel && htrans[1] && hready;

  always_comb
  begin
    case ({haddr[7:2], 2'b00})
      OFS_CTRL: rd_mux = {29'h0, retain_ff, 1'b0, run_ff};
      OFS_INV: rd_mux = inv_ff;
      OFS_CON: rd_mux = con_ff;
      OFS_STAT: rd_mux = {24'h0, gate_q};
      OFS_SFB: rd_mux = {29'h0, sfb_q_ff, sfb_inv_ff, sfb_con_ff};
      OFS_SFB_CNT: rd_mux = {16'h0, sfb_cnt_ff};
      OFS_HOURS: rd_mux = hours_ff;
      OFS_PINS: rd_mux = {27'h0, pin_sync};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // zero wait states; read data latched in the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_ff <= BUS_IDLE;
      waddr_ff <= '0;
      hrdata_ff <= '0;
      hreadyout_ff <= 1'b0;
    end
    else
    begin
      hreadyout_ff <= 1'b1;
      if (hready)
      begin
        case (bus_ff)
          BUS_IDLE, BUS_WR, BUS_RD:
          begin
            if (ap_ok && hwrite)
              bus_ff <= BUS_WR;
            else if (ap_ok)
              bus_ff <= BUS_RD;
            else
              bus_ff <= BUS_IDLE;
          end
          default: bus_ff <= BUS_IDLE;
        endcase
        if (ap_ok)
          waddr_ff <= haddr[7:2];
        if (ap_ok && !hwrite)
          hrdata_ff <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_ff <= RUN_RST;
      retain_ff <= RETAIN_RST;
      restart_ff <= 1'b0;
      inv_ff <= INV_RST;
      con_ff <= CON_RST;
      sfb_con_ff <= SFB_CON_RST;
      sfb_inv_ff <= SFB_INV_RST;
    end
    else
    begin
      restart_ff <= 1'b0;
      if (bus_ff == BUS_WR)
      begin
        case ({waddr_ff, 2'b00})
          OFS_CTRL:
          begin
            run_ff <= hwdata[CTRL_RUN_BIT];
            restart_ff <= hwdata[CTRL_RESTART_BIT];
            retain_ff <= hwdata[CTRL_RETAIN_BIT];
          end
          OFS_INV: inv_ff <= hwdata;
          OFS_CON: con_ff <= hwdata;
          OFS_SFB:
          begin
            sfb_con_ff <= hwdata[SFB_CON_BIT];
            sfb_inv_ff <= hwdata[SFB_INV_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign dout = dout_ff;
  assign sfb_q = sfb_q_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_RETAIN_ON: assert property (@(posedge hclk) disable iff (!hresetn)
    (restart_ff && retain_ff) |=> (sfb_cnt_ff == $past(sfb_cnt_ff) && sfb_q_ff == $past(sfb_q_ff)))
    else $error("retained state lost on restart");

  AST_RETAIN_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    (restart_ff && !retain_ff) |=> (sfb_cnt_ff == '0 && !sfb_q_ff))
    else $error("state kept without retention");

  AST_HOURS: assert property (@(posedge hclk) disable iff (!hresetn)
    restart_ff |=> (hours_ff == $past(hours_ff)))
    else $error("hours counter disturbed by restart");

  AST_SFB_OPEN: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick_ff && !restart_ff && !sfb_con_ff) |=> (sfb_cnt_ff == '0 && !sfb_q_ff))
    else $error("open sfb input not low");

  AST_DOUT: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> (dout_ff == $past(gate_q)))
    else $error("output terminal altered");

  // one sample per evaluation cycle, so the tick lasts one clock when CYC_DIV is above 1
  AST_TICK_ONCE: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick_ff && (CYC_DIV > 1)) |=> !tick_ff)
    else $error("evaluation tick longer than one cycle");

  AST_HOURS_COUNT: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick_ff && !restart_ff) |=> (hours_ff == $past(hours_ff) + 32'h0000_0001))
    else $error("hours counter missed an evaluation cycle");

endmodule // lgc_top

// ---- lgc_term_model.sv ----
// Purpose: input terminals and a downstream block for the gate bank
// Assumes: pins are levels, moved just after hclk rises
// Notes: counts edge pulses and their length in clocks

`timescale 1ns/10ps

module lgc_term_model (
  // clock
  input wire logic hclk,
  // requested levels
  input wire logic [3:0] pin_req,
  input wire logic trg_req,
  // device side
  output logic [3:0] din_pin,
  output logic sfb_trg_pin,
  input wire logic [7:0] dout,
  // observed pulses
  output int npulse_and,
  output int npulse_nand,
  output int last_len
);
  int run_len;
  logic [7:0] dout_d;

  initial
  begin
    din_pin = 4'h0;
    sfb_trg_pin = 1'b0;
    npulse_and = 0;
    npulse_nand = 0;
    last_len = 0;
    run_len = 0;
    dout_d = 8'h00;
  end

  always @(posedge hclk)
  begin
    din_pin <= pin_req;
    sfb_trg_pin <= trg_req;
  end

  // watched on the falling edge, away from the output register update
  always @(negedge hclk)
  begin
    dout_d <= dout;
    if (dout[1] && !dout_d[1]) npulse_and <= npulse_and + 1;
    if (dout[3] && !dout_d[3]) npulse_nand <= npulse_nand + 1;
    if (dout[1] || dout[3]) run_len <= run_len + 1;
    else if (run_len != 0)
    begin
      last_len <= run_len;
      run_len <= 0;
    end
  end
endmodule // lgc_term_model

// ---- tb_top.sv ----
// Purpose: self-checking bench for the gate bank over ahb-lite
// Assumes: short evaluation cycle set through CYC_DIV
// Notes: reads queue an expectation, a monitor compares in the data phase

`timescale 1ns/10ps

module tb_top;
  import lgc_pkg::*;
  localparam int CYC = 4;
  localparam int ST = 6 * CYC;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, sfb_q;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic [3:0] pin_req = 4'h0, din_pin;
  logic trg_req = 1'b0, sfb_trg_pin, rd_dph = 1'b0;
  logic [7:0] dout, stat;
  logic [31:0] inv, con, exp_q[$];
  int npulse_and, npulse_nand, last_len, base_a, base_n;
  int num_errors = 0, n_checks = 0, seed = 83891;

  always #12.5 hclk = ~hclk;

  lgc_top #(.CYC_DIV(CYC), .SFB_DELAY(SFB_DELAY_CYC)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .din_pin(din_pin), .sfb_trg_pin(sfb_trg_pin), .dout(dout),
    .sfb_q(sfb_q));

  lgc_term_model term_u (.hclk(hclk), .pin_req(pin_req), .trg_req(trg_req),
    .din_pin(din_pin), .sfb_trg_pin(sfb_trg_pin), .dout(dout), .npulse_and(npulse_and),
    .npulse_nand(npulse_nand), .last_len(last_len));

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // unconnected inputs: high for the and/nand family, low for the rest
  function automatic logic [7:0] gate_exp(input logic [3:0] d, input logic [31:0] iv,
                                          input logic [31:0] cn);
    logic [7:0] r;
    logic [3:0] x;
    for (int i = 0; i < 8; i++)
    begin
      for (int j = 0; j < 4; j++)
        x[j] = cn[4*i+j] ? d[j] ^ iv[4*i+j] : (i < 4);
      case (i)
        0: r[i] = &x;
        2: r[i] = ~&x;
        4: r[i] = |x;
        5: r[i] = ~|x;
        6: r[i] = x[0] ^ x[1];
        7: r[i] = ~x[0];
        default: r[i] = 1'b0;
      endcase
    end
    return r;
  endfunction

  // ----------------------------------------
  // bus master
  // ----------------------------------------
  task automatic ahb_req(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
    ahb_req(a, 1'b1, d);
  endtask

  task automatic ahb_rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ahb_req(a, 1'b0, 32'h0000_0000);
  endtask

  always @(posedge hclk)
  begin
    if (rd_dph && hreadyout === 1'b1)
    begin
      chk(hrdata, exp_q.pop_front());
      chk({31'd0, hresp}, 32'h0000_0000);
    end
    rd_dph <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  task automatic end_test(input string name);
    repeat (2) @(posedge hclk);
    $display("done %s at %0t", name, $time);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    $display("FAIL %0t watchdog expired", $time);
    report_and_stop;
  end

  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (ST) @(posedge hclk);
    ahb_rd(OFS_CTRL, 32'h0000_0001);
    ahb_rd(OFS_INV, INV_RST);
    ahb_rd(OFS_CON, CON_RST);
    ahb_rd(OFS_SFB, 32'h0000_0001);
    ahb_wr(8'h20, 32'hFFFF_FFFF);
    ahb_rd(8'h20, 32'h0000_0000);
    ahb_wr(OFS_STAT, 32'h0000_00FF);
    ahb_rd(OFS_STAT, {24'd0, gate_exp(4'h0, INV_RST, CON_RST)});
    end_test("reset values");

    for (int k = 0; k < 36; k++)
    begin
      inv = (k < 16) ? 32'h0000_0000 : $random(seed);
      con = (k < 16) ? 32'hFFFF_FFFF : $random(seed);
      inv = inv & con;
      pin_req <= (k < 16) ? k[3:0] : 4'($random(seed));
      trg_req <= 1'($random(seed));
      ahb_wr(OFS_INV, inv);
      ahb_wr(OFS_CON, con);
      repeat (ST) @(posedge hclk);
      stat = gate_exp(pin_req, inv, con);
      chk({24'd0, dout}, {24'd0, stat});
      ahb_rd(OFS_STAT, {24'd0, stat});
      ahb_rd(OFS_PINS, {27'd0, trg_req, pin_req});
    end
    end_test("truth tables");

    ahb_wr(OFS_INV, 32'h0000_0000);
    ahb_wr(OFS_CON, 32'hFFFF_FF3F);
    pin_req <= 4'h0;
    repeat (ST) @(posedge hclk);
    base_a = npulse_and;
    base_n = npulse_nand;
    pin_req <= 4'h3;
    repeat (2 * ST) @(posedge hclk);
    chk(npulse_and, base_a + 1);
    chk(last_len, CYC);
    pin_req <= 4'hF;
    repeat (2 * ST) @(posedge hclk);
    chk(npulse_and, base_a + 1);
    chk(npulse_nand, base_n);
    pin_req <= 4'hE;
    repeat (2 * ST) @(posedge hclk);
    chk(npulse_nand, base_n + 1);
    chk(last_len, CYC);
    end_test("edge blocks");

    ahb_wr(OFS_CTRL, 32'h0000_0000);
    pin_req <= 4'hF;
    repeat (ST) @(posedge hclk);
    ahb_rd(OFS_STAT, {24'd0, gate_exp(4'hE, 32'h0000_0000, 32'hFFFF_FF3F)});
    ahb_wr(OFS_CTRL, 32'h0000_0001);
    end_test("run stop");

    ahb_wr(OFS_SFB, 32'h0000_0001);
    trg_req <= 1'b1;
    repeat (2 * ST) @(posedge hclk);
    chk({31'd0, sfb_q}, 32'h0000_0001);
    ahb_rd(OFS_SFB, 32'h0000_0005);
    ahb_wr(OFS_CTRL, 32'h0000_0003);
    ahb_rd(OFS_SFB, 32'h0000_0001);
    repeat (2 * ST) @(posedge hclk);
    ahb_wr(OFS_CTRL, 32'h0000_0005);
    ahb_wr(OFS_CTRL, 32'h0000_0007);
    ahb_rd(OFS_SFB, 32'h0000_0005);
    ahb_rd(OFS_SFB_CNT, SFB_DELAY_CYC);
    ahb_rd(OFS_CTRL, 32'h0000_0005);
    ahb_wr(OFS_CTRL, 32'h0000_0001);
    trg_req <= 1'b0;
    repeat (ST) @(posedge hclk);
    ahb_rd(OFS_SFB, 32'h0000_0001);
    ahb_wr(OFS_SFB, 32'h0000_0000);
    trg_req <= 1'b1;
    repeat (2 * ST) @(posedge hclk);
    ahb_rd(OFS_SFB, 32'h0000_0000);
    ahb_wr(OFS_SFB, 32'h0000_0003);
    trg_req <= 1'b0;
    repeat (2 * ST) @(posedge hclk);
    ahb_rd(OFS_SFB, 32'h0000_0007);
    end_test("special function");
    report_and_stop;
  end
endmodule // tb_top
